//--- logic/rcu_pkg.sv
// constants, field layout and types of the reset and clock unit
// assumes one 20 MHz reference clock (mclk) feeding the whole unit
package rcu_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int FILT_NS = 200;
  localparam int FILT_CYC = (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REF_WAIT_CYC = 768;
  localparam int BUS_WAIT_CYC = 8;
  localparam int REL_CYC = FILT_CYC + REF_WAIT_CYC + BUS_WAIT_CYC;
  localparam int REL_W = 10;
  localparam logic [REL_W-1:0] REL_LAST = REL_W'(REL_CYC - 1);
  localparam logic [2:0] FILT_LAST = 3'(FILT_CYC - 1);
  // register byte offsets
  localparam logic [7:0] ADDR_CLKCTRL = 8'h00;
  localparam logic [7:0] ADDR_DIV = 8'h04;
  localparam logic [7:0] ADDR_GATE = 8'h08;
  localparam logic [7:0] ADDR_FLAGS = 8'h0c;
  localparam logic [7:0] ADDR_WDG = 8'h10;
  localparam logic [7:0] ADDR_SERVICE = 8'h14;
  // field positions
  localparam int CTL_PLLON = 4;
  localparam int CTL_MUL_LSB = 8;
  localparam int CTL_LOCKIE = 16;
  localparam int CTL_SWRST = 31;
  localparam int DIV_APB_LSB = 0;
  localparam int DIV_ATA_LSB = 8;
  localparam int FLG_SW = 0;
  localparam int FLG_WDG = 1;
  localparam int FLG_LOCK = 8;
  localparam int WDG_EN = 31;
  // reset values and codes
  localparam logic [3:0] MUL_RST = 4'h1;
  localparam logic [3:0] DIV_RST = 4'h0;
  localparam logic [15:0] WDG_PER_RST = 16'hffff;
  localparam logic [31:0] SERVICE_KEY = 32'h0000_a55a;
  localparam logic [31:0] RESET_VECTOR = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // main clock sources
  typedef enum logic [2:0] {
    SRC_REF, SRC_DIV2, SRC_DIV32, SRC_DIV64, SRC_PLL, SRC_SLOW
  } rcu_src_t;
  // reset sequencer states
  typedef enum logic [1:0] {ST_RUN, ST_PINLOW, ST_RELEASE} rcu_state_t;
endpackage : rcu_pkg

//--- logic/rcu_reset_clock_unit.sv
// reset and clock unit: clock source select, prescalers, gates, reset seq
// assumes all inputs synchronous to mclk; clocks leave as enable strobes
//
// Summary of operation
// - main clock from ref, ref/2, ref/32, ref/64, PLL or slow clock
// - peripheral bus clock made by programmable prescaler from main clock
// - disk interface clock made by its own independent prescaler
// - each peripheral clock can be frozen by its own gate bit
// - PLL lock change in either direction signals wake-up unit if enabled
// - fast bus and synchronous peripheral bus share one main clock
// - low level on reset pin resets the whole chip
// - writing a control bit forces a software reset
// - enabled watchdog expiring unserviced resets the chip
// - after reset the flag bit of its cause is set
// - pin reset leaves all cause flags cleared
// - pin reset overrides every other condition
// - during reset registers take their reset values
// - only pin lows at least as long as the filter width start reset
// - release waits filter plus 768 ref plus 8 bus cycles
// - on release the reset vector at address zero is presented
// - after reset undivided reference clock is system clock and PLL input
// - after reset PLL is off, bypassed, multiplier one
// - after reset most peripheral clocks are stopped
module rcu_reset_clock_unit #(
  parameter int NPERIPH = 16,
  parameter logic [NPERIPH-1:0] GATE_RST = '0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins and sources
  input wire logic rstPinN,
  input wire logic pllLock,
  input wire logic pllTick,
  input wire logic slowTick,
  // reset outputs
  output logic sysRstN,
  output logic [31:0] resetVector,
  // clock outputs
  output logic sysClkEn,
  output logic apbClkEn,
  output logic ataClkEn,
  output logic [NPERIPH-1:0] periphClkEn,
  // pll control and wake-up
  output logic pllPowerOn,
  output logic pllBypass,
  output logic [3:0] pllMult,
  output logic lockWake
);
  import rcu_pkg::*;

  rcu_state_t state_r, stateNxt;
  logic [REL_W-1:0] relCnt_r;
  logic [REL_W-1:0] relAge_r;
  logic [2:0] lowCnt_r;
  logic sysRstN_r, pinHit, swReq, wdgHit, inRun;
  logic [1:0] flags_r;
  rcu_src_t selReg_r, selAct_r;
  logic pllOn_r, lockIe_r, pllBypass_r, lockPrev_r, lockWake_r;
  logic [3:0] mul_r;
  logic [11:0] divReg_r;
  logic [NPERIPH-1:0] gate_r, periphEn_r;
  logic [15:0] wdgPer_r, wdgCnt_r;
  logic wdgEn_r;
  logic [5:0] refCnt_r;
  logic srcTick, sysTick_r;
  logic [3:0] presDiv [2];
  logic [3:0] presCnt_r [2];
  logic [1:0] presTick_r;
  logic [31:0] resetVector_r;
  logic awRdy_r, wRdy_r, awHeld_r, wHeld_r, bvalid_r, arRdy_r, rvalid_r;
  logic awHs, wHs, arHs, wrFire, awHeldNxt, wHeldNxt, bvalidNxt, rvalidNxt;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r, rdata_r, merged;
  logic [3:0] wStrb_r;
  logic [1:0] bresp_r, rresp_r;

  // address decode shared by write and read paths
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == ADDR_CLKCTRL) || (a == ADDR_DIV) ||
      (a == ADDR_GATE) || (a == ADDR_FLAGS) || (a == ADDR_WDG) ||
      (a == ADDR_SERVICE);
  endfunction : isMapped

  // readback word of one register
  function automatic logic [31:0] regWord(input logic [7:0] a);
    regWord = 32'h0;
    case (a)
      ADDR_CLKCTRL:
      begin
        regWord[2:0] = selReg_r;
        regWord[CTL_PLLON] = pllOn_r;
        regWord[CTL_MUL_LSB +: 4] = mul_r;
        regWord[CTL_LOCKIE] = lockIe_r;
      end
      ADDR_DIV: regWord[11:0] = divReg_r;
      ADDR_GATE: regWord[NPERIPH-1:0] = gate_r;
      ADDR_FLAGS:
      begin
        regWord[1:0] = flags_r;
        regWord[FLG_LOCK] = pllLock;
      end
      ADDR_WDG:
      begin
        regWord[15:0] = wdgPer_r;
        regWord[WDG_EN] = wdgEn_r;
      end
      ADDR_SERVICE: regWord[15:0] = wdgCnt_r;
      default: regWord = 32'h0;
    endcase
  endfunction : regWord

  // byte-lane merge of write data into the old word
  function automatic logic [31:0] applyStrb(input logic [31:0] o,
    input logic [31:0] d, input logic [3:0] s);
    applyStrb = o;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
        applyStrb[8*i +: 8] = d[8*i +: 8];
    end
  endfunction : applyStrb

  // invalid source codes fall back to the reference clock
  function automatic rcu_src_t toSrc(input logic [2:0] v);
    toSrc = (v > SRC_SLOW) ? SRC_REF : rcu_src_t'(v);
  endfunction : toSrc

  // axi handshake terms
  assign awHs = s_axi_awvalid && awRdy_r;
  assign wHs = s_axi_wvalid && wRdy_r;
  assign arHs = s_axi_arvalid && arRdy_r;
  assign wrFire = awHeld_r && wHeld_r && !bvalid_r;
  assign awHeldNxt = (awHeld_r || awHs) && !wrFire;
  assign wHeldNxt = (wHeld_r || wHs) && !wrFire;
  assign bvalidNxt = wrFire || (bvalid_r && !s_axi_bready);
  assign rvalidNxt = arHs || (rvalid_r && !s_axi_rready);
  assign merged = applyStrb(regWord(awAddr_r), wData_r, wStrb_r);

  // write channel: address and data taken in either order
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      awRdy_r <= 1'b0;
      wRdy_r <= 1'b0;
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      awAddr_r <= 8'h00;
      wData_r <= 32'h0;
      wStrb_r <= 4'h0;
    end
    else
    begin
      awRdy_r <= !awHeldNxt && !bvalidNxt;
      wRdy_r <= !wHeldNxt && !bvalidNxt;
      awHeld_r <= awHeldNxt;
      wHeld_r <= wHeldNxt;
      bvalid_r <= bvalidNxt;
      if (awHs)
        awAddr_r <= {s_axi_awaddr[7:2], 2'h0};
      if (wHs)
      begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (wrFire)
        bresp_r <= isMapped(awAddr_r) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // read channel: data one cycle after the address is taken
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      arRdy_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
    end
    else
    begin
      arRdy_r <= !rvalidNxt;
      rvalid_r <= rvalidNxt;
      if (arHs)
      begin
        rdata_r <= regWord({s_axi_araddr[7:2], 2'h0});
        rresp_r <= isMapped({s_axi_araddr[7:2], 2'h0}) ? RESP_OKAY :
          RESP_SLVERR;
      end
    end
  end

  // reset request terms
  assign inRun = (state_r == ST_RUN);
  assign pinHit = !rstPinN && (lowCnt_r == FILT_LAST);
  assign swReq = wrFire && inRun && (awAddr_r == ADDR_CLKCTRL) &&
    wStrb_r[3] && wData_r[CTL_SWRST];
  assign wdgHit = wdgEn_r && (wdgCnt_r == 16'h0000);

  // reset pin filter counts consecutive low cycles
  always_ff @(posedge mclk)
  begin
    if (srst || rstPinN)
      lowCnt_r <= 3'h0;
    else if (lowCnt_r != FILT_LAST)
      lowCnt_r <= lowCnt_r + 3'h1;
  end

  // reset sequencer next state, pin first
  always_comb
  begin
    stateNxt = state_r;
    case (state_r)
      ST_RUN:
        if (pinHit)
          stateNxt = ST_PINLOW;
        else if (swReq || wdgHit)
          stateNxt = ST_RELEASE;
      ST_PINLOW:
        if (rstPinN)
          stateNxt = ST_RELEASE;
      ST_RELEASE:
        if (pinHit)
          stateNxt = ST_PINLOW;
        else if (relCnt_r == REL_LAST)
          stateNxt = ST_RUN;
      default: stateNxt = ST_RELEASE;
    endcase
  end

  // reset sequencer registers and release counter
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      state_r <= ST_RELEASE;
      relCnt_r <= '0;
      sysRstN_r <= 1'b0;
      resetVector_r <= RESET_VECTOR;
    end
    else
    begin
      state_r <= stateNxt;
      sysRstN_r <= (stateNxt == ST_RUN);
      resetVector_r <= RESET_VECTOR;
      if (stateNxt == ST_RELEASE && state_r != ST_RELEASE)
        relCnt_r <= '0;
      else if (state_r == ST_RELEASE)
        relCnt_r <= relCnt_r + 1'b1;
    end
  end

  // reset cause flags, cleared by pin reset or write one
  always_ff @(posedge mclk)
  begin
    if (srst || pinHit)
      flags_r <= 2'h0;
    else if (inRun && (swReq || wdgHit))
      flags_r <= {wdgHit, swReq};
    else if (wrFire && awAddr_r == ADDR_FLAGS && wStrb_r[0])
      flags_r <= flags_r & ~wData_r[1:0];
  end

  // configuration registers, held at reset values outside run
  always_ff @(posedge mclk)
  begin
    if (srst || !inRun)
    begin
      selReg_r <= SRC_REF;
      pllOn_r <= 1'b0;
      mul_r <= MUL_RST;
      lockIe_r <= 1'b0;
      divReg_r <= {DIV_RST, 4'h0, DIV_RST};
      gate_r <= GATE_RST;
      wdgPer_r <= WDG_PER_RST;
      wdgEn_r <= 1'b0;
    end
    else if (wrFire)
    begin
      case (awAddr_r)
        ADDR_CLKCTRL:
        begin
          selReg_r <= toSrc(merged[2:0]);
          pllOn_r <= merged[CTL_PLLON];
          mul_r <= merged[CTL_MUL_LSB +: 4];
          lockIe_r <= merged[CTL_LOCKIE];
        end
        ADDR_DIV: divReg_r <= merged[11:0];
        ADDR_GATE: gate_r <= merged[NPERIPH-1:0];
        ADDR_WDG:
        begin
          wdgPer_r <= merged[15:0];
          wdgEn_r <= wdgEn_r || merged[WDG_EN];
        end
        default: gate_r <= gate_r;
      endcase
    end
  end

  // watchdog down-counter on main clock ticks, reloaded by service key
  always_ff @(posedge mclk)
  begin
    if (srst || !inRun || !wdgEn_r)
      wdgCnt_r <= wdgPer_r;
    else if (wrFire && awAddr_r == ADDR_SERVICE && wData_r == SERVICE_KEY &&
      wStrb_r == 4'hf)
      wdgCnt_r <= wdgPer_r;
    else if (sysTick_r && wdgCnt_r != 16'h0000)
      wdgCnt_r <= wdgCnt_r - 16'h0001;
  end

  // source tick of the active main clock selection
  always_comb
  begin
    case (selAct_r)
      SRC_REF: srcTick = 1'b1;
      SRC_DIV2: srcTick = refCnt_r[0];
      SRC_DIV32: srcTick = (refCnt_r[4:0] == 5'h1f);
      SRC_DIV64: srcTick = (refCnt_r == 6'h3f);
      SRC_PLL: srcTick = pllOn_r ? pllTick : 1'b1;
      SRC_SLOW: srcTick = slowTick;
      default: srcTick = 1'b1;
    endcase
  end

  // main clock select switches only at a source period boundary
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      selAct_r <= SRC_REF;
      refCnt_r <= 6'h00;
      sysTick_r <= 1'b0;
      pllBypass_r <= 1'b1;
    end
    else
    begin
      sysTick_r <= srcTick;
      pllBypass_r <= !(selAct_r == SRC_PLL && pllOn_r);
      if (srcTick && selAct_r != selReg_r)
      begin
        selAct_r <= selReg_r;
        refCnt_r <= 6'h00;
      end
      else
        refCnt_r <= refCnt_r + 6'h01;
    end
  end

  // peripheral bus and disk interface prescalers on main ticks
  assign presDiv[0] = divReg_r[DIV_APB_LSB +: 4];
  assign presDiv[1] = divReg_r[DIV_ATA_LSB +: 4];
  for (genvar p = 0; p < 2; p++)
  begin : g_pres
    always_ff @(posedge mclk)
    begin
      if (srst)
      begin
        presCnt_r[p] <= 4'h0;
        presTick_r[p] <= 1'b0;
      end
      else
      begin
        presTick_r[p] <= srcTick && (presCnt_r[p] >= presDiv[p]);
        if (srcTick)
          presCnt_r[p] <= (presCnt_r[p] >= presDiv[p]) ? 4'h0 :
            presCnt_r[p] + 4'h1;
      end
    end
  end

  // per-peripheral gated main clock enables
  for (genvar i = 0; i < NPERIPH; i++)
  begin : g_gate
    always_ff @(posedge mclk)
    begin
      if (srst)
        periphEn_r[i] <= 1'b0;
      else
        periphEn_r[i] <= gate_r[i] && srcTick;
    end
  end

  // lock change detector toward the wake-up unit
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      lockPrev_r <= 1'b0;
      lockWake_r <= 1'b0;
    end
    else
    begin
      lockPrev_r <= pllLock;
      lockWake_r <= lockIe_r && (pllLock != lockPrev_r);
    end
  end

  // outputs straight from flip-flops
  assign s_axi_awready = awRdy_r;
  assign s_axi_wready = wRdy_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arRdy_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign sysRstN = sysRstN_r;
  assign resetVector = resetVector_r;
  assign sysClkEn = sysTick_r;
  assign apbClkEn = presTick_r[0];
  assign ataClkEn = presTick_r[1];
  assign periphClkEn = periphEn_r;
  assign pllPowerOn = pllOn_r;
  assign pllBypass = pllBypass_r;
  assign pllMult = mul_r;
  assign lockWake = lockWake_r;

  // cycles spent in release, counted apart from the sequencer counter
  always_ff @(posedge mclk)
  begin
    if (srst || state_r != ST_RELEASE)
      relAge_r <= '0;
    else if (relAge_r != '1)
      relAge_r <= relAge_r + 1'b1;
  end

  // release sequence after pin rise
  sequence s_relWait;
    !sysRstN_r [*8];
  endsequence
  property p_release;
    @(posedge mclk) disable iff (srst)
    (state_r == ST_PINLOW && rstPinN) |=> s_relWait;
  endproperty
  a_release: assert property (p_release)
    else $error("release wait too short");

  // system reset rises exactly when the release count is used up
  property p_relLen;
    @(posedge mclk) disable iff (srst)
    (state_r == ST_RELEASE || (inRun && relAge_r != '0)) |->
      (sysRstN_r == (relAge_r == REL_W'(REL_CYC)));
  endproperty
  a_relLen: assert property (p_relLen)
    else $error("release wait length wrong");

  property p_filtHit;
    @(posedge mclk) disable iff (srst)
    (inRun && !rstPinN && lowCnt_r == FILT_LAST) |=>
      (state_r == ST_PINLOW && !sysRstN_r);
  endproperty
  a_filtHit: assert property (p_filtHit)
    else $error("filtered pin low did not reset");

  sequence s_shortLow;
    (inRun && rstPinN) ##1 !rstPinN [*3] ##1 rstPinN;
  endsequence
  property p_filtShort;
    @(posedge mclk) disable iff (srst)
    s_shortLow |=> (inRun || $past(swReq) || $past(wdgHit));
  endproperty
  a_filtShort: assert property (p_filtShort)
    else $error("short pin low caused reset");

  property p_pinFlags;
    @(posedge mclk) disable iff (srst)
    pinHit |=> (flags_r == 2'h0 && !sysRstN_r);
  endproperty
  a_pinFlags: assert property (p_pinFlags)
    else $error("pin reset left cause flags set");

  property p_swFlag;
    @(posedge mclk) disable iff (srst)
    (swReq && !pinHit) |=> (flags_r[FLG_SW] && !sysRstN_r &&
      state_r == ST_RELEASE);
  endproperty
  a_swFlag: assert property (p_swFlag)
    else $error("software reset not flagged");

  property p_wdg;
    @(posedge mclk) disable iff (srst)
    (inRun && wdgHit && !pinHit) |=> (state_r == ST_RELEASE &&
      flags_r[FLG_WDG]);
  endproperty
  a_wdg: assert property (p_wdg)
    else $error("watchdog expiry did not reset");

  property p_lock;
    @(posedge mclk) disable iff (srst)
    (lockIe_r && $changed(pllLock)) |=> lockWake_r;
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock change not signalled");

  property p_rstCfg;
    @(posedge mclk) disable iff (srst)
    (!inRun) |=> (selReg_r == SRC_REF && !pllOn_r && mul_r == MUL_RST &&
      gate_r == GATE_RST && !wdgEn_r);
  endproperty
  a_rstCfg: assert property (p_rstCfg)
    else $error("registers not at reset values");

  property p_glitch;
    @(posedge mclk) disable iff (srst)
    $changed(selAct_r) |-> ($past(srcTick) && refCnt_r == 6'h00);
  endproperty
  a_glitch: assert property (p_glitch)
    else $error("clock switched mid period");
endmodule : rcu_reset_clock_unit

//--- verif/rcu_pll_model.sv
// oscillator side model: pll lock and pll and slow clock period strobes
// assumes the unit drives pll power on; pll ticks only while powered
module rcu_pll_model #(
  parameter int PLL_DIV = 4,
  parameter int SLOW_DIV = 16,
  parameter int LOCK_DLY = 8
) (
  // clock and pll control
  input wire logic mclk,
  input wire logic pllPowerOn,
  // oscillator outputs
  output logic pllLock,
  output logic pllTick,
  output logic slowTick
);
  timeunit 1ns;
  timeprecision 1ns;
  int pllCnt_r = 0;
  int slowCnt_r = 0;
  int lockCnt_r = 0;

  // pll output period counter, stopped while powered off
  always_ff @(posedge mclk)
  begin
    if (pllPowerOn && pllCnt_r < PLL_DIV - 1)
      pllCnt_r <= pllCnt_r + 1;
    else
      pllCnt_r <= 0;
  end

  // lock comes a while after power on and drops at once when off
  always_ff @(posedge mclk)
  begin
    if (!pllPowerOn)
      lockCnt_r <= 0;
    else if (lockCnt_r < LOCK_DLY)
      lockCnt_r <= lockCnt_r + 1;
  end

  // slow oscillator runs free
  always_ff @(posedge mclk)
  begin
    slowCnt_r <= (slowCnt_r == SLOW_DIV - 1) ? 0 : slowCnt_r + 1;
  end

  // strobes and lock level
  assign pllTick = pllPowerOn && pllCnt_r == PLL_DIV - 1;
  assign slowTick = slowCnt_r == SLOW_DIV - 1;
  assign pllLock = lockCnt_r == LOCK_DLY;
endmodule : rcu_pll_model

//--- verif/testbench.sv
// self-checking bench of the reset and clock unit over axi4-lite
// assumes the oscillator model supplies lock and source strobes
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import rcu_pkg::*;
  localparam int LIM = 2000;
  localparam logic [31:0] SRC_CFG [6] = '{32'h100, 32'h101, 32'h102,
    32'h103, 32'h114, 32'h105};
  localparam logic [31:0] SRC_EXP [6] = '{128, 64, 4, 2, 32, 8};
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic rstPinN = 1'b1;
  logic [7:0] awAddr = '0;
  logic [7:0] arAddr = '0;
  logic [31:0] wData = '0;
  logic [3:0] wStrb = '0;
  logic awValid = 1'b0;
  logic wValid = 1'b0;
  logic bReady = 1'b0;
  logic arValid = 1'b0;
  logic rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid;
  logic [1:0] bResp, rResp, resp;
  logic [31:0] rData, resetVector, d;
  logic sysRstN, sysClkEn, apbClkEn, ataClkEn, lockWake;
  logic pllPowerOn, pllBypass, pllLock, pllTick, slowTick;
  logic [3:0] pllMult;
  logic [15:0] periphClkEn;
  int failures = 0;
  int nTests = 0;
  int n, cSys, cApb, cAta, cP0, cP1, cWake;
  bit counting = 0;

  rcu_reset_clock_unit rcu_reset_clock_unit_i (.mclk(mclk), .srst(srst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .rstPinN(rstPinN), .pllLock(pllLock),
    .pllTick(pllTick), .slowTick(slowTick), .sysRstN(sysRstN),
    .resetVector(resetVector), .sysClkEn(sysClkEn), .apbClkEn(apbClkEn),
    .ataClkEn(ataClkEn), .periphClkEn(periphClkEn),
    .pllPowerOn(pllPowerOn), .pllBypass(pllBypass), .pllMult(pllMult),
    .lockWake(lockWake));

  rcu_pll_model rcu_pll_model_i (.mclk(mclk), .pllPowerOn(pllPowerOn),
    .pllLock(pllLock), .pllTick(pllTick), .slowTick(slowTick));

  // 20 MHz reference clock
  initial
  begin
    forever #25 mclk = ~mclk;
  end

  // strobe counters, armed and disarmed between edges
  always @(posedge mclk)
  begin
    if (counting)
    begin
      cSys += int'(sysClkEn === 1'b1);
      cApb += int'(apbClkEn === 1'b1);
      cAta += int'(ataClkEn === 1'b1);
      cP0 += int'(periphClkEn[0] === 1'b1);
      cP1 += int'(periphClkEn[1] === 1'b1);
      cWake += int'(lockWake === 1'b1);
    end
  end

  task automatic summarize();
    $display("counts: %0d checks, %0d mismatches", nTests, failures);
    if (failures == 0 && nTests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic stall();
    check(32'h0, 32'h1);
    summarize();
  endtask : stall

  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
  endtask : tick

  task automatic axiWr(input logic [7:0] a, input logic [31:0] v,
    output logic [1:0] r);
    int k;
    bit aw;
    bit w;
    k = 0;
    aw = 0;
    w = 0;
    awAddr <= a;
    awValid <= 1'b1;
    wData <= v;
    wStrb <= 4'hf;
    wValid <= 1'b1;
    while (!(aw && w) && k < LIM)
    begin
      @(posedge mclk);
      k++;
      if (!aw && awReady === 1'b1)
      begin
        aw = 1;
        awValid <= 1'b0;
      end
      if (!w && wReady === 1'b1)
      begin
        w = 1;
        wValid <= 1'b0;
      end
    end
    bReady <= 1'b1;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (bValid !== 1'b1 && k < LIM);
    r = bResp;
    bReady <= 1'b0;
    if (k >= LIM)
      stall();
  endtask : axiWr

  task automatic axiRd(input logic [7:0] a, output logic [31:0] v,
    output logic [1:0] r);
    int k;
    k = 0;
    arAddr <= a;
    arValid <= 1'b1;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (arReady !== 1'b1 && k < LIM);
    arValid <= 1'b0;
    rReady <= 1'b1;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (rValid !== 1'b1 && k < LIM);
    v = rData;
    r = rResp;
    rReady <= 1'b0;
    if (k >= LIM)
      stall();
  endtask : axiRd

  task automatic startCount();
    @(negedge mclk);
    {cSys, cApb, cAta, cP0, cP1, cWake} = '0;
    counting = 1;
    @(posedge mclk);
  endtask : startCount

  task automatic stopCount();
    @(negedge mclk);
    counting = 0;
    @(posedge mclk);
  endtask : stopCount

  // counts edges until the unit leaves reset and checks the release time;
  // done is the number of edges already passed since the release began
  task automatic waitHigh(input int done);
    n = done;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (sysRstN !== 1'b1 && n < LIM);
    if (n >= LIM)
      stall();
    check(32'(n >= REL_CYC && n <= REL_CYC + 4), 32'h1);
  endtask : waitHigh

  // main sequence
  initial
  begin
    tick(20);
    srst <= 1'b0;
    waitHigh(0);
    check(resetVector, RESET_VECTOR);
    check(32'({pllPowerOn, pllBypass, pllMult}), 32'h11);
    check(32'(periphClkEn), 32'h0);
    axiRd(ADDR_CLKCTRL, d, resp);
    check(d, 32'h0000_0100);
    axiRd(ADDR_WDG, d, resp);
    check(d, 32'h0000_ffff);
    axiRd(8'h20, d, resp);
    check({d[29:0], resp}, {30'h0, RESP_SLVERR});
    axiWr(8'h20, 32'h1, resp);
    check(32'(resp), 32'(RESP_SLVERR));
    $display("test reset values done");
    // lock change: disabled, falling enabled, rising enabled
    startCount();
    axiWr(ADDR_CLKCTRL, 32'h0000_0110, resp);
    tick(30);
    stopCount();
    check(32'(cWake), 32'h0);
    startCount();
    axiWr(ADDR_CLKCTRL, 32'h0001_0100, resp);
    tick(30);
    stopCount();
    check(32'(cWake), 32'h1);
    startCount();
    axiWr(ADDR_CLKCTRL, 32'h0001_0110, resp);
    tick(30);
    stopCount();
    check(32'(cWake), 32'h1);
    $display("test lock wake done");
    foreach (SRC_CFG[i])
    begin
      axiWr(ADDR_CLKCTRL, SRC_CFG[i], resp);
      tick(70);
      startCount();
      tick(127);
      stopCount();
      check(32'(cSys), SRC_EXP[i]);
      if (i == 4)
        check(32'(pllBypass), 32'h0);
    end
    $display("test clock sources done");
    axiWr(ADDR_CLKCTRL, 32'h0000_0100, resp);
    axiWr(ADDR_DIV, 32'h0000_0103, resp);
    check(32'(resp), 32'(RESP_OKAY));
    axiWr(ADDR_GATE, 32'h0000_0001, resp);
    tick(20);
    startCount();
    tick(127);
    stopCount();
    check(32'(cApb), 32'd32);
    check(32'(cAta), 32'd64);
    check(32'(cP0), 32'd128);
    check(32'(cP1), 32'h0);
    $display("test prescalers and gates done");
    axiWr(ADDR_CLKCTRL, 32'h8000_0100, resp);
    tick(2);
    check(32'(sysRstN), 32'h0);
    // reset began at the write's commit edge, three edges ago
    waitHigh(3);
    axiRd(ADDR_FLAGS, d, resp);
    check(d & 32'h3, 32'h1);
    axiWr(ADDR_FLAGS, 32'h3, resp);
    axiRd(ADDR_DIV, d, resp);
    check(d, 32'h0);
    $display("test software reset done");
    axiWr(ADDR_WDG, 32'h8000_0040, resp);
    repeat (6)
    begin
      axiWr(ADDR_SERVICE, SERVICE_KEY, resp);
      tick(8);
    end
    check(32'(sysRstN), 32'h1);
    tick(80);
    check(32'(sysRstN), 32'h0);
    // expiry came 65 edges after the last reload, 24 edges ago
    waitHigh(24);
    axiRd(ADDR_FLAGS, d, resp);
    check(d & 32'h3, 32'h2);
    $display("test watchdog done");
    axiWr(ADDR_GATE, 32'h0000_0005, resp);
    rstPinN <= 1'b0;
    tick(3);
    rstPinN <= 1'b1;
    tick(10);
    check(32'(sysRstN), 32'h1);
    rstPinN <= 1'b0;
    tick(8);
    check(32'(sysRstN), 32'h0);
    rstPinN <= 1'b1;
    waitHigh(0);
    axiRd(ADDR_FLAGS, d, resp);
    check(d & 32'h3, 32'h0);
    axiRd(ADDR_GATE, d, resp);
    check(d, 32'h0);
    $display("test pin reset done");
    summarize();
  end
endmodule : testbench
